// ===== slave_timer_cfg.svh
`ifndef SLAVE_TIMER_CFG_SVH
`define SLAVE_TIMER_CFG_SVH
`define OFF_MODE 8'h00
`define OFF_CMP 8'h04
`define OFF_TOM 8'h08
`define OFF_TOL 8'h0c
`define OFF_TOV 8'h10
`define OFF_TOE 8'h14
`define OFF_START 8'h18
`define OFF_STOP 8'h1c
`define OFF_STATUS 8'h20
`define OFF_CNT 8'h24
`define CH_BIT 1
`define SPLIT_BIT 11
`define TRIG_HI 10
`define TRIG_LO 8
`define EDGE_HI 7
`define EDGE_LO 6
`define MD_HI 3
`define MD_LO 1
`define MD_LOW_BIT 0
`define MODE_MASK 16'hdfcf
`define TRIG_SW 3'h0
`define TRIG_EDGE 3'h1
`define TRIG_BOTH 3'h2
`define TRIG_MASTER 3'h4
`define ES_FALL 2'h0
`define ES_RISE 2'h1
`define ES_LOW 2'h2
`define ES_HIGH 2'h3
`define MD_INTERVAL 3'h0
`define MD_CAPTURE 3'h2
`define MD_EVENT 3'h3
`define MD_ONE 3'h4
`define MD_CAPONE 3'h6
`define CNT_ONE 16'h0001
`define CNT_ZERO 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== slave_timer_pkg.sv
package slave_timer_pkg;
	typedef enum logic {IDLE, COUNTING} run_t;
	typedef struct packed {
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
		logic [15:0] mode;
		logic [15:0] cmp;
		logic tom;
		logic tol;
		logic tov;
		logic toe;
		logic en;
		run_t run;
		logic [15:0] cnt;
		logic pin_prev;
		logic irq;
	} state_t;
endpackage

// ===== slave_timer_channel_pwm.sv
// Contract
// - Trigger code 000: only a software start starts the channel.
// - Trigger code 001: valid input edge is both start and capture.
// - Trigger code 010: one input edge starts, the other captures.
// - Trigger code 100: master interrupt starts; other codes prohibited.
// - Edge select 00 picks falling edge, 01 picks rising edge.
// - Edge select 10: falling edge starts, rising edge captures (low width).
// - Edge select 11: rising edge starts, falling edge captures (high width).
// - Modes: interval 000 down, capture 010 up, event counter 011 down.
// - Interval or capture with low bit 1: interrupt and output change at start.
// - Interval, capture, event with low bit 0: no interrupt at start.
// - One-count low bit 0: retrigger while counting ignored, no interrupt.
// - One-count low bit 1: retrigger while counting accepted with interrupt.
// - Capture-and-one-count forces low bit 0: no start interrupt, no retrigger.
// - Duty percent equals slave value over master value plus one, times 100.
// - Output mode bit 0: output toggles on each own interrupt.
// - Output mode bit 1: master interrupt sets, own interrupt resets output.
// - Polarity bit 0 active high, 1 active low.
// - Output value bit holds the current timer output level.
// - Output enable register holds one independent enable per channel.
// - Enable 0: pin shows software value; enable 1: timer drives, writes ignored.
// - Split bit 0 gives 16-bit operation for the slave.
// - Writing 1 to start bit sets enable status; writing 0 does nothing.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`include "slave_timer_cfg.svh"
module slave_timer_channel_pwm
	import slave_timer_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic count_tick_i,
	input wire logic slave_input_pin_i,
	input wire logic master_interrupt_i,
	output logic timer_output_o,
	output logic channel_interrupt_o
);
	state_t st;
	state_t next_st;
	logic aw_hs;
	logic w_hs;
	logic do_wr;
	logic [7:0] wr_addr;
	logic [15:0] wr_data;
	logic [1:0] wr_strb;
	logic sw_start;
	logic [2:0] trig;
	logic [1:0] es;
	logic [2:0] md;
	logic low;
	logic rise;
	logic fall;
	logic st_edge;
	logic op_edge;
	logic start_trig;
	logic cap_trig;
	logic run_en;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [15:0] ch16(input logic b);
		ch16 = 16'(b) << `CH_BIT;
	endfunction

	assign s_axi_awready_o = !st.aw_got && !st.bvalid;
	assign s_axi_wready_o = !st.w_got && !st.bvalid;
	assign s_axi_arready_o = !st.rvalid;
	assign s_axi_bvalid_o = st.bvalid;
	assign s_axi_bresp_o = st.bresp;
	assign s_axi_rvalid_o = st.rvalid;
	assign s_axi_rresp_o = st.rresp;
	assign s_axi_rdata_o = {16'h0000, st.rdata};
	assign timer_output_o = st.tov;
	assign channel_interrupt_o = st.irq;

	assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
	assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
	// address and data may arrive in either order; the write fires once both are held
	assign do_wr = (st.aw_got || aw_hs) && (st.w_got || w_hs) && !st.bvalid;
	assign wr_addr = st.aw_got ? st.awaddr : {s_axi_awaddr_i[7:2], 2'h0};
	assign wr_data = st.w_got ? st.wdata : s_axi_wdata_i[15:0];
	assign wr_strb = st.w_got ? st.wstrb : s_axi_wstrb_i[1:0];
	assign sw_start = do_wr && (wr_addr == `OFF_START) && wr_strb[0] && wr_data[`CH_BIT];
	// the start write counts in its own cycle, else a software start would be lost
	assign run_en = st.en || sw_start;

	assign trig = st.mode[`TRIG_HI:`TRIG_LO];
	assign es = st.mode[`EDGE_HI:`EDGE_LO];
	assign md = st.mode[`MD_HI:`MD_LO];
	// low bit has no effect in capture-and-one-count
	assign low = st.mode[`MD_LOW_BIT] && (md != `MD_CAPONE);
	// pin is already synchronous to clock_i
	assign rise = slave_input_pin_i && !st.pin_prev;
	assign fall = !slave_input_pin_i && st.pin_prev;
	// even codes start on falling, odd on rising
	assign st_edge = es[0] ? rise : fall;
	assign op_edge = es[0] ? fall : rise;

	always_comb begin
		start_trig = 1'b0;
		cap_trig = 1'b0;
		case (trig)
			`TRIG_SW: start_trig = sw_start;
			`TRIG_EDGE: begin
				start_trig = st_edge;
				cap_trig = st_edge;
			end
			// edges split between start and capture
			`TRIG_BOTH: begin
				start_trig = st_edge;
				cap_trig = op_edge;
			end
			`TRIG_MASTER: start_trig = master_interrupt_i;
			default: start_trig = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.irq = 1'b0;
		next_st.pin_prev = slave_input_pin_i;
		if (st.bvalid && s_axi_bready_i) begin
			next_st.bvalid = 1'b0;
		end
		if (aw_hs) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = {s_axi_awaddr_i[7:2], 2'h0};
		end
		if (w_hs) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata_i[15:0];
			next_st.wstrb = s_axi_wstrb_i[1:0];
		end
		if (do_wr) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `RESP_OKAY;
			case (wr_addr)
				// split bit is kept but only 16-bit counting exists
				`OFF_MODE: next_st.mode = merge16(st.mode, wr_data, wr_strb) & `MODE_MASK;
				`OFF_CMP: next_st.cmp = merge16(st.cmp, wr_data, wr_strb);
				`OFF_TOM: if (wr_strb[0]) next_st.tom = wr_data[`CH_BIT];
				`OFF_TOL: if (wr_strb[0]) next_st.tol = wr_data[`CH_BIT];
				// value bit is software owned only while timer output is off
				`OFF_TOV: if (wr_strb[0] && !st.toe) next_st.tov = wr_data[`CH_BIT];
				`OFF_TOE: if (wr_strb[0]) next_st.toe = wr_data[`CH_BIT];
				`OFF_START: if (sw_start) next_st.en = 1'b1;
				`OFF_STOP: if (wr_strb[0] && wr_data[`CH_BIT]) next_st.en = 1'b0;
				`OFF_STATUS, `OFF_CNT: next_st.bresp = `RESP_OKAY;
				default: next_st.bresp = `RESP_SLVERR;
			endcase
			// set beats clear when start and stop land in one write cycle
			if (sw_start) begin
				next_st.en = 1'b1;
			end
		end
		if (st.rvalid && s_axi_rready_i) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = `RESP_OKAY;
			case ({s_axi_araddr_i[7:2], 2'h0})
				`OFF_MODE: next_st.rdata = st.mode;
				`OFF_CMP: next_st.rdata = st.cmp;
				`OFF_TOM: next_st.rdata = ch16(st.tom);
				`OFF_TOL: next_st.rdata = ch16(st.tol);
				`OFF_TOV: next_st.rdata = ch16(st.tov);
				`OFF_TOE: next_st.rdata = ch16(st.toe);
				`OFF_START, `OFF_STOP: next_st.rdata = `CNT_ZERO;
				`OFF_STATUS: next_st.rdata = ch16(st.en);
				`OFF_CNT: next_st.rdata = st.cnt;
				default: begin
					next_st.rdata = `CNT_ZERO;
					next_st.rresp = `RESP_SLVERR;
				end
			endcase
		end
		if (!run_en) begin
			next_st.run = IDLE;
		end else begin
			case (md)
				`MD_INTERVAL, `MD_EVENT: begin
					if (start_trig) begin
						next_st.cnt = st.cmp;
						next_st.run = COUNTING;
						// start interrupt only for interval with low bit set
						next_st.irq = low && (md == `MD_INTERVAL);
					end else if (st.run == COUNTING &&
						((md == `MD_INTERVAL) ? count_tick_i : st_edge)) begin
						if (st.cnt == `CNT_ZERO) begin
							next_st.cnt = st.cmp;
							next_st.irq = 1'b1;
						end else begin
							next_st.cnt = st.cnt - `CNT_ONE;
						end
					end
				end
				`MD_CAPTURE: begin
					if (st.run == IDLE) begin
						if (start_trig) begin
							next_st.cnt = `CNT_ZERO;
							next_st.run = COUNTING;
							// start interrupt follows the low bit
							next_st.irq = low;
						end
					end else if (cap_trig) begin
						next_st.cmp = st.cnt;
						next_st.cnt = `CNT_ZERO;
						next_st.irq = 1'b1;
					end else if (count_tick_i) begin
						next_st.cnt = st.cnt + `CNT_ONE;
					end
				end
				`MD_ONE: begin
					// retrigger acceptance follows the low bit
					if (start_trig && (st.run == IDLE || low)) begin
						next_st.cnt = st.cmp;
						next_st.run = COUNTING;
						next_st.irq = (st.run == COUNTING);
					end else if (st.run == COUNTING && count_tick_i) begin
						// interrupt at zero, then wait for a trigger
						if (st.cnt <= `CNT_ONE) begin
							next_st.cnt = `CNT_ZERO;
							next_st.irq = 1'b1;
							next_st.run = IDLE;
						end else begin
							next_st.cnt = st.cnt - `CNT_ONE;
						end
					end
				end
				`MD_CAPONE: begin
					if (st.run == IDLE) begin
						if (start_trig) begin
							next_st.cnt = `CNT_ZERO;
							next_st.run = COUNTING;
						end
					end else if (cap_trig) begin
						next_st.cmp = st.cnt;
						next_st.irq = 1'b1;
						next_st.run = IDLE;
					end else if (count_tick_i) begin
						next_st.cnt = st.cnt + `CNT_ONE;
					end
				end
				default: next_st.run = IDLE;
			endcase
		end
		// duty comes from cmp ticks active within a master period of the master value plus one
		if (st.toe) begin
			if (st.tom) begin
				// reset to idle level, master set wins on a tie
				if (next_st.irq) begin
					next_st.tov = st.tol;
				end
				if (master_interrupt_i && st.en) begin
					next_st.tov = !st.tol;
				end
			end else if (next_st.irq) begin
				next_st.tov = !st.tov;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	AST_SW_ONLY: assert property (st.en && trig == `TRIG_SW && md == `MD_ONE && st.run == IDLE
		&& !sw_start |=> st.run == IDLE) else $error("start without software trigger");
	AST_EDGE_CAP: assert property (st.en && trig == `TRIG_EDGE && md == `MD_CAPTURE
		&& st.run == COUNTING && st_edge |=> st.cmp == $past(st.cnt)) else $error("edge capture lost");
	AST_TWO_EDGE: assert property (st.en && trig == `TRIG_BOTH && md == `MD_CAPONE
		&& st.run == IDLE && st_edge |=> st.run == COUNTING && st.cnt == `CNT_ZERO)
		else $error("start edge ignored");
	AST_MASTER: assert property (st.en && trig == `TRIG_MASTER && md == `MD_ONE
		&& st.run == IDLE && master_interrupt_i |=> st.run == COUNTING && st.cnt == $past(st.cmp))
		else $error("master trigger ignored");
	AST_RISE_ONLY: assert property (st.en && trig == `TRIG_EDGE && es == `ES_RISE
		&& md == `MD_ONE && st.run == IDLE && fall |=> st.run == IDLE) else $error("wrong edge");
	AST_LOW_WIDTH: assert property (st.en && trig == `TRIG_BOTH && es == `ES_LOW
		&& md == `MD_CAPONE && st.run == COUNTING && rise |=> st.run == IDLE && channel_interrupt_o)
		else $error("low width capture missed");
	AST_HIGH_WIDTH: assert property (st.en && trig == `TRIG_BOTH && es == `ES_HIGH
		&& md == `MD_CAPONE && st.run == COUNTING && fall |=> st.run == IDLE && channel_interrupt_o)
		else $error("high width capture missed");
	AST_COUNT_UP: assert property (st.en && md == `MD_CAPTURE && st.run == COUNTING
		&& count_tick_i && !cap_trig |=> st.cnt == $past(st.cnt) + `CNT_ONE) else $error("no count up");
	AST_START_IRQ: assert property (run_en && md == `MD_INTERVAL && low && start_trig
		|=> channel_interrupt_o) else $error("start interrupt missing");
	AST_RETRIG_OFF: assert property (st.en && md == `MD_ONE && !low && st.run == COUNTING
		&& start_trig && !count_tick_i |=> !channel_interrupt_o && $stable(st.cnt))
		else $error("retrigger not ignored");
	AST_RETRIG_ON: assert property (st.en && md == `MD_ONE && low && st.run == COUNTING
		&& start_trig |=> channel_interrupt_o && st.cnt == $past(st.cmp)) else $error("retrigger lost");
	AST_PWM_SET: assert property (st.en && st.toe && st.tom && master_interrupt_i
		|=> timer_output_o == !$past(st.tol)) else $error("output not set by master");
	AST_OUT_HOLD: assert property (!st.toe && !(do_wr && wr_addr == `OFF_TOV)
		|=> $stable(timer_output_o)) else $error("software output moved");
	AST_START_EN: assert property (sw_start |=> st.en) else $error("start bit not taken");
	AST_ONE_STOP: assert property (st.en && md == `MD_ONE && st.run == COUNTING
		&& count_tick_i && st.cnt == `CNT_ONE && !start_trig
		|=> st.run == IDLE && channel_interrupt_o ##1 (st.run == IDLE || $past(start_trig)))
		else $error("one-count did not stop");

	// the unselected pin edge never starts a one-count channel
	AST_FALL_ONLY: assert property (st.en && trig == `TRIG_EDGE && es == `ES_FALL
		&& md == `MD_ONE && st.run == IDLE && rise |=> st.run == IDLE)
		else $error("rising edge started a falling-edge channel");
	// prohibited mode codes leave the counter parked
	AST_BAD_MODE: assert property (!(md inside {`MD_INTERVAL, `MD_CAPTURE, `MD_EVENT,
		`MD_ONE, `MD_CAPONE}) |=> st.run == IDLE) else $error("prohibited mode counted");
	AST_QUIET_START: assert property (run_en && st.run == IDLE && start_trig
		&& !st.mode[`MD_LOW_BIT] && (md inside {`MD_INTERVAL, `MD_CAPTURE, `MD_EVENT})
		|=> !channel_interrupt_o) else $error("start interrupt with low bit clear");
	AST_CAPONE_QUIET: assert property (run_en && md == `MD_CAPONE && st.run == IDLE
		&& start_trig |=> st.run == COUNTING && !channel_interrupt_o)
		else $error("capture start not quiet");
	AST_CAPONE_RETRIG: assert property (st.en && md == `MD_CAPONE && st.run == COUNTING
		&& start_trig && !cap_trig |=> st.run == COUNTING && !channel_interrupt_o)
		else $error("capture retrigger taken");

	// output pin follows the interrupts only while the timer owns it
	AST_TOGGLE: assert property (st.toe && !st.tom && next_st.irq
		|=> timer_output_o == !$past(timer_output_o)) else $error("output did not toggle");
	AST_PWM_CLR: assert property (st.toe && st.tom && next_st.irq
		&& !(master_interrupt_i && st.en) |=> timer_output_o == $past(st.tol))
		else $error("output not reset by own interrupt");

	// stop, or no start yet, keeps the counter idle
	AST_IDLE_OFF: assert property (!st.en && !sw_start |=> st.run == IDLE)
		else $error("counting while disabled");
endmodule

// ===== master_channel_model.sv
// stands in for the master channel: one interrupt pulse every period_i+1 ticks
module master_channel_model (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic [15:0] period_i,
	output logic interrupt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt;
	// a stopped master is reset to zero so the first tick after a run fires at once
	always @(posedge clock_i) begin
		interrupt_o <= 1'b0;
		if (reset_i || !run_i) begin
			cnt <= 16'h0000;
		end else if (tick_i) begin
			if (cnt == 16'h0000) begin
				cnt <= period_i;
				interrupt_o <= 1'b1;
			end else begin
				cnt <= cnt - 16'h0001;
			end
		end
	end
endmodule

// ===== tb_slave_timer_channel_pwm.sv
`include "slave_timer_cfg.svh"
module tb_slave_timer_channel_pwm;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic arv = 1'b0;
	logic tick = 1'b1;
	logic pin = 1'b0;
	logic mrun = 1'b0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h00000000;
	logic awr, wrd, bv, arr, rv, tout, irq, mi;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int n_mismatch = 0;
	int checked = 0;
	int n_irq = 0;
	int hi = 0;
	always #5 clk = ~clk;
	slave_timer_channel_pwm u_slave_timer_channel_pwm (.clock_i(clk), .reset_i(rst),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .count_tick_i(tick),
		.slave_input_pin_i(pin), .master_interrupt_i(mi), .timer_output_o(tout),
		.channel_interrupt_o(irq));
	master_channel_model u_master_channel_model (.clock_i(clk), .reset_i(rst),
		.tick_i(tick), .run_i(mrun), .period_i(16'h0009), .interrupt_o(mi));
	always @(posedge clk) begin
		if (tout === 1'b1) hi <= hi + 1;
		if (irq === 1'b1) n_irq <= n_irq + 1;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// bready and rready stay high, so the answer is taken at the edge it is seen
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		awa <= a;
		wd <= {16'h0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (bv !== 1'b1);
		chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		ara <= a;
		arv <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		chk($sformatf("rresp %h", a), 32'h0, {30'h0, rresp});
		chk($sformatf("reg %h", a), {16'h0000, e}, rdata);
	endtask
	task automatic meas(input int eh, input int ei);
		int h, q, k;
		k = 0;
		while (k < 1) begin @(posedge clk); if (mi) k++; end
		h = hi;
		q = n_irq;
		while (k < 4) begin @(posedge clk); if (mi) k++; end
		chk("high cycles", eh, hi - h);
		chk("irq count", ei, n_irq - q);
	endtask
	task automatic t_regs;
		rc(`OFF_MODE, 16'h0000);
		rc(`OFF_STATUS, 16'h0000);
		wr(`OFF_MODE, 16'hffff, `RESP_OKAY);
		rc(`OFF_MODE, `MODE_MASK);
		wr(8'h40, 16'h1234, `RESP_SLVERR);
		wr(`OFF_CNT, 16'h5555, `RESP_OKAY);
		rc(`OFF_CNT, 16'h0000);
		wr(`OFF_TOE, 16'hffff, `RESP_OKAY);
		rc(`OFF_TOE, 16'h0002);
		wr(`OFF_TOE, 16'h0000, `RESP_OKAY);
	endtask
	task automatic t_outsw;
		wr(`OFF_TOV, 16'h0002, `RESP_OKAY);
		cyc(2);
		chk("pin", 32'h1, {31'h0, tout});
		wr(`OFF_TOE, 16'h0002, `RESP_OKAY);
		wr(`OFF_TOV, 16'h0000, `RESP_OKAY);
		rc(`OFF_TOV, 16'h0002);
		wr(`OFF_TOE, 16'h0000, `RESP_OKAY);
		wr(`OFF_TOV, 16'h0000, `RESP_OKAY);
		cyc(2);
		chk("pin", 32'h0, {31'h0, tout});
	endtask
	// one-count slave behind a 10-tick master: three ticks high per period, then seven once polarity is active low
	task automatic t_pwm;
		wr(`OFF_MODE, 16'h0408, `RESP_OKAY);
		wr(`OFF_CMP, 16'h0003, `RESP_OKAY);
		wr(`OFF_TOM, 16'h0002, `RESP_OKAY);
		wr(`OFF_TOE, 16'h0002, `RESP_OKAY);
		wr(`OFF_START, 16'h0002, `RESP_OKAY);
		rc(`OFF_STATUS, 16'h0002);
		mrun <= 1'b1;
		cyc(25);
		meas(9, 3);
		wr(`OFF_TOL, 16'h0002, `RESP_OKAY);
		cyc(25);
		meas(21, 3);
		wr(`OFF_STOP, 16'h0002, `RESP_OKAY);
		wr(`OFF_TOL, 16'h0000, `RESP_OKAY);
	endtask
	// master keeps pulsing here, which software-only triggering must ignore
	task automatic t_sw;
		int q;
		logic o;
		wr(`OFF_MODE, 16'h0001, `RESP_OKAY);
		wr(`OFF_CMP, 16'h00c8, `RESP_OKAY);
		wr(`OFF_TOM, 16'h0000, `RESP_OKAY);
		cyc(2);
		q = n_irq;
		o = tout;
		wr(`OFF_START, 16'h0002, `RESP_OKAY);
		cyc(3);
		chk("start irq", 32'h1, n_irq - q);
		chk("toggled pin", {31'h0, ~o}, {31'h0, tout});
		cyc(40);
		chk("irq after master", 32'h1, n_irq - q);
		wr(`OFF_STOP, 16'h0002, `RESP_OKAY);
	endtask
	task automatic t_retrig;
		int q;
		for (int k = 0; k < 2; k++) begin
			wr(`OFF_MODE, {15'h0004, k[0]}, `RESP_OKAY);
			wr(`OFF_START, 16'h0002, `RESP_OKAY);
			cyc(3);
			q = n_irq;
			// no tick while the retrigger lands, so an ignored one leaves the count alone
			tick <= 1'b0;
			wr(`OFF_START, 16'h0002, `RESP_OKAY);
			tick <= 1'b1;
			cyc(3);
			chk("retrigger irq", k, n_irq - q);
			wr(`OFF_STOP, 16'h0002, `RESP_OKAY);
		end
	endtask
	task automatic t_edge;
		int q;
		for (int k = 0; k < 2; k++) begin
			pin <= k[0];
			wr(`OFF_MODE, {8'h01, 1'b0, k[0], 6'h08}, `RESP_OKAY);
			wr(`OFF_CMP, 16'h0003, `RESP_OKAY);
			wr(`OFF_START, 16'h0002, `RESP_OKAY);
			cyc(3);
			q = n_irq;
			pin <= ~k[0];
			cyc(8);
			chk("wrong edge irq", 32'h0, n_irq - q);
			pin <= k[0];
			cyc(8);
			chk("valid edge irq", 32'h1, n_irq - q);
			wr(`OFF_STOP, 16'h0002, `RESP_OKAY);
		end
	endtask
	// one tick per cycle: the start edge clears the count, so six cycles read back as five
	task automatic t_cap;
		int q;
		for (int k = 2; k < 4; k++) begin
			pin <= ~k[0];
			wr(`OFF_MODE, {8'h02, k[1:0], 6'h0c}, `RESP_OKAY);
			wr(`OFF_START, 16'h0002, `RESP_OKAY);
			cyc(3);
			q = n_irq;
			pin <= k[0];
			cyc(6);
			pin <= ~k[0];
			cyc(3);
			chk("width irq", 32'h1, n_irq - q);
			rc(`OFF_CMP, 16'h0005);
			wr(`OFF_STOP, 16'h0002, `RESP_OKAY);
		end
		wr(`OFF_MODE, 16'h0144, `RESP_OKAY);
		wr(`OFF_START, 16'h0002, `RESP_OKAY);
		cyc(3);
		q = n_irq;
		pin <= 1'b1;
		cyc(2);
		pin <= 1'b0;
		cyc(5);
		pin <= 1'b1;
		cyc(3);
		chk("capture irq", 32'h1, n_irq - q);
		rc(`OFF_CMP, 16'h0006);
		wr(`OFF_STOP, 16'h0002, `RESP_OKAY);
	endtask
	// event counter steps on falling pin edges only, reloading after zero
	task automatic t_event;
		int q;
		wr(`OFF_CMP, 16'h0001, `RESP_OKAY);
		wr(`OFF_MODE, 16'h0006, `RESP_OKAY);
		q = n_irq;
		wr(`OFF_START, 16'h0002, `RESP_OKAY);
		for (int k = 0; k < 4; k++) begin
			pin <= ~pin;
			cyc(2);
		end
		chk("event irq", 32'h1, n_irq - q);
		wr(`OFF_STOP, 16'h0002, `RESP_OKAY);
	endtask
	task automatic print_verdict;
		$display("mismatches %0d of %0d comparisons", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_outsw();
		t_pwm();
		t_sw();
		t_retrig();
		t_edge();
		t_cap();
		t_event();
		print_verdict();
	end
	// the whole sequence needs well under 2000 cycles
	initial begin
		#100us;
		n_mismatch++;
		print_verdict();
	end
endmodule
